/* bench/pmt_core_model.sv */
// Purpose: Core-side model that takes table read results
// Assumes: At most one table read in flight
// Notes:   Data memory held as four sectors of 256 bytes
`timescale 1ns/1ps
module pmt_core_model (
    input wire logic       pclk,          // System clock
    input wire logic       presetn,       // Async reset, active low
    input wire logic       dm_wr_en,      // Data memory write pulse
    input wire logic [1:0] dm_wr_sector,  // Destination sector
    input wire logic [7:0] dm_wr_addr,    // Destination offset
    input wire logic [7:0] dm_wr_data,    // Low table byte
    input wire logic       core_stall     // Hold-off request
);
    logic [7:0] dmem [4][256];
    int         stall_cnt;
    int         last_stall;
    int         n_wr;
    // Next fetch waits while held; count the held cycles
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stall_cnt <= 0;
            n_wr      <= 0;
        end else begin
            if (core_stall)
                stall_cnt <= stall_cnt + 1;
            else if (dm_wr_en)
                stall_cnt <= 0;
            if (dm_wr_en) begin
                last_stall                     <= stall_cnt;
                dmem[dm_wr_sector][dm_wr_addr] <= dm_wr_data;
                n_wr                           <= n_wr + 1;
            end
        end
    end
endmodule

/* bench/program_memory_table_read_tb_top.sv */
// Purpose: Self-checking bench for the table read block
// Assumes: Four-bank variant, APB with one wait state
// Notes:   Each table read first loads the word it will fetch
`timescale 1ns/1ps
module program_memory_table_read_tb_top;
    import pmt_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, dm_wr_en, core_stall, err;
    logic [1:0]  dm_wr_sector;
    logic [7:0]  dm_wr_addr, dm_wr_data;
    logic [14:0] pc_out;
    int          n_mismatch = 0, compares = 0, n0;
    int          tblp, tbhp, bank, pc, latch;
    int          mem[int];
    int          bad[3] = '{32'h4, 32'h300, 32'h3};

    always #20 pclk = ~pclk;

    pmt_table_read i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dm_wr_en(dm_wr_en), .dm_wr_sector(dm_wr_sector),
        .dm_wr_addr(dm_wr_addr), .dm_wr_data(dm_wr_data), .core_stall(core_stall),
        .pc_out(pc_out));
    pmt_core_model u_core (.pclk(pclk), .presetn(presetn), .dm_wr_en(dm_wr_en),
        .dm_wr_sector(dm_wr_sector), .dm_wr_addr(dm_wr_addr), .dm_wr_data(dm_wr_data),
        .core_stall(core_stall));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic stop_test;
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; hold everything until pready seen high
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) n_mismatch++;
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input int d);
        xfer(a, 1'b1, d);
        chk("pslverr", 0, err);
    endtask

    task automatic rdchk(input logic [7:0] a, input int exp, input string nm);
        xfer(a, 1'b0, 0);
        chk(nm, exp, rd);
    endtask

    // Reference address per form, load a word there, then fetch it
    task automatic tread(input int mode, input int sec, input int dst);
        int a, k;
        a = (mode == 0) ? (tbhp << 8) | tblp : (mode == 1) ?
            (bank << 13) | (pc & 'h1f00) | tblp : 'h7f00 | tblp;
        mem[a] = $urandom & 'hffff;
        wr(PMT_OFS_LDADDR, a);
        wr(PMT_OFS_LDDATA, mem[a]);
        n0 = u_core.n_wr;
        wr(PMT_OFS_CMD, mode | ((sec != 0) << 2) | (sec << 8) | (dst << 16));
        k = 0;
        // Wait for completion before the next command
        while (u_core.n_wr == n0 && k < 8) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 8) n_mismatch++;
        latch = mem[a] >> 8;
        chk("dmem", mem[a] & 'hff, u_core.dmem[sec][dst]);
        chk("stall", 2, u_core.last_stall);
        rdchk(PMT_OFS_LATCH, latch, "latch");
        rdchk(PMT_OFS_STAT, (mem[a] & 'hff) << 8, "status");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(1));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 7; i++) rdchk(i * 4, 0, "reset_reg");
        chk("pc_out", 0, pc_out);
        xfer(8'h24, 1'b0, 0);
        chk("unmapped_err", 1, err);
        latch = $urandom & 'hff;
        wr(PMT_OFS_LATCH, latch);
        rdchk(PMT_OFS_LATCH, latch, "latch_rw");
        for (int i = 0; i < 12; i++) begin
            tblp = (i == 0) ? 'hff : $urandom & 'hff;
            tbhp = $urandom & 'h7f;
            bank = $urandom & 3;
            pc = $urandom & 'h1fff;
            wr(PMT_OFS_TBLP, tblp);
            wr(PMT_OFS_TBHP, tbhp);
            wr(PMT_OFS_BANK, bank);
            wr(PMT_OFS_PC, pc);
            chk("pc_out", (bank << 13) | pc, pc_out);
            tread(i % 3, $urandom & 3, $urandom & 'hff);
            wr(PMT_OFS_TBLP, tblp ^ 1);
            rdchk(PMT_OFS_LATCH, latch, "latch_hold");
        end
        // Forms that mismatch sector and extended bit, and the unused mode 3, are refused
        foreach (bad[j]) begin
            n0 = u_core.n_wr;
            xfer(PMT_OFS_CMD, 1'b1, bad[j]);
            chk("refuse_err", 1, err);
            xfer(PMT_OFS_STAT, 1'b0, 0);
            chk("err_flag", 1, rd[1]);
            wr(PMT_OFS_STAT, 2);
            xfer(PMT_OFS_STAT, 1'b0, 0);
            chk("err_clear", 0, rd[1]);
            chk("no_write", n0, u_core.n_wr);
        end
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("pc_out_rst", 0, pc_out);
        rdchk(PMT_OFS_PC, 0, "pc_rst");
        stop_test;
    end

    // Hang guard, far beyond the under one thousand cycles needed
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        stop_test;
    end
endmodule

/* common/pmt_pkg.sv */
// Purpose: Shared constants for the program memory table read block
// Assumes: APB register map, 32-bit data, one word per register
// Notes:   Offsets are byte addresses; fields sit at the bit positions given below
package pmt_pkg;
    // ----------------------------------------------------------------
    // Memory geometry
    // ----------------------------------------------------------------
    localparam int PMT_WORDS_SMALL    = 16384;   // Two-bank variant
    localparam int PMT_WORDS_LARGE    = 32768;   // Four-bank variant
    localparam int PMT_WORD_BITS      = 16;
    localparam int PMT_PAGE_BITS      = 8;       // 256 words per page
    localparam int PMT_BANK_SPAN_BITS = 13;      // 8K words per bank
    localparam int PMT_TBL_CYCLES     = 2;       // Table read length

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] PMT_OFS_TBLP   = 8'h00;  // Table pointer low
    localparam logic [7:0] PMT_OFS_TBHP   = 8'h04;  // Table pointer high
    localparam logic [7:0] PMT_OFS_BANK   = 8'h08;  // Bank pointer
    localparam logic [7:0] PMT_OFS_LATCH  = 8'h0c;  // Table-high latch
    localparam logic [7:0] PMT_OFS_PC     = 8'h10;  // Program counter low 13 bits
    localparam logic [7:0] PMT_OFS_CMD    = 8'h14;  // Table read command
    localparam logic [7:0] PMT_OFS_STAT   = 8'h18;  // Status
    localparam logic [7:0] PMT_OFS_LDADDR = 8'h1c;  // Image load address
    localparam logic [7:0] PMT_OFS_LDDATA = 8'h20;  // Image load data

    // ----------------------------------------------------------------
    // Command and status fields
    // ----------------------------------------------------------------
    localparam int PMT_CMD_MODE_LSB = 0;    // 2 bits
    localparam int PMT_CMD_EXT_BIT  = 2;    // Extended form
    localparam int PMT_CMD_SEC_LSB  = 8;    // 2 bits, destination sector
    localparam int PMT_CMD_DST_LSB  = 16;   // 8 bits, destination offset
    localparam int PMT_STAT_BUSY    = 0;
    localparam int PMT_STAT_ERR     = 1;    // Write 1 to clear
    localparam int PMT_STAT_LO_LSB  = 8;    // Last low byte read

    // Table read forms
    localparam logic [1:0] PMT_MODE_FULL = 2'b00;  // Both pointers
    localparam logic [1:0] PMT_MODE_PAGE = 2'b01;  // Current page
    localparam logic [1:0] PMT_MODE_LAST = 2'b10;  // Last page

    // Reset values
    localparam logic [7:0]  PMT_RST_BYTE = 8'h00;
    localparam logic [12:0] PMT_RST_PC   = 13'h0000;  // Reset vector

    typedef enum logic [1:0] {
        PMT_IDLE  = 2'b00,
        PMT_FETCH = 2'b01
    } pmt_state_e;
endpackage

/* hw/pmt_prog_mem.sv */
// Purpose: Program word store with registered read data
// Assumes: One port; write and read never in the same cycle
// Notes:   Contents are undefined until loaded
`timescale 1ns/1ps
module pmt_prog_mem #(
    parameter int WORDS = 32768,
    parameter int WIDTH = 16,
    parameter int AW    = $clog2(WORDS)
) (
    input  wire logic             pclk,     // System clock
    input  wire logic             wr_en,    // Write strobe
    input  wire logic [AW-1:0]    addr,     // Word address
    input  wire logic [WIDTH-1:0] wr_data,  // Write word
    input  wire logic             rd_en,    // Read strobe
    output logic      [WIDTH-1:0] rd_data   // Registered read word
);
    logic [WIDTH-1:0] mem [WORDS];

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    // No reset on the array so it maps onto block memory
    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= mem[addr];
        end
    end
endmodule

/* hw/pmt_table_read.sv */
// Purpose: Program memory access with banking, reset vector, table reads
// Assumes: APB slave, one wait state per transfer, pclk at 25 MHz
// Notes:   Program counter is a stand-in writable over the bus
//
// Function
// - Program memory holds 16-bit words, 16K or 32K deep.
// - Bank is bank_pointer bit 0, or bits 1..0 on four banks.
// - Program counter is zero after every reset.
// - Full table address joins low and high table pointers.
// - Table read writes the word's low byte to the destination register.
// - Table read loads the word's high byte into the table-high latch.
// - Page form uses the low pointer as offset in the current page.
// - Extended form only for destinations outside sector 0.
// - Last-page form ignores the high table pointer.
// - Every table read takes two cycles with the core held off.
// - Table-high latch is readable and writable by software.
// - A page is 256 words; page offsets wrap within it.
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module pmt_table_read
    import pmt_pkg::*;
#(
    parameter int MEM_WORDS = PMT_WORDS_LARGE,
    parameter int AW        = $clog2(MEM_WORDS),
    parameter int BB        = AW - PMT_BANK_SPAN_BITS,
    parameter int HW        = AW - PMT_PAGE_BITS
) (
    input  wire logic          pclk,          // System clock
    input  wire logic          presetn,       // Async reset, active low
    input  wire logic          psel,          // APB select
    input  wire logic          penable,       // APB enable
    input  wire logic          pwrite,        // APB direction
    input  wire logic [7:0]    paddr,         // APB byte address
    input  wire logic [31:0]   pwdata,        // APB write data
    output logic      [31:0]   prdata,        // APB read data
    output logic               pready,        // APB ready
    output logic               pslverr,       // APB error
    output logic               dm_wr_en,      // Data memory write pulse
    output logic      [1:0]    dm_wr_sector,  // Destination sector
    output logic      [7:0]    dm_wr_addr,    // Destination offset
    output logic      [7:0]    dm_wr_data,    // Low table byte
    output logic               core_stall,    // Hold next instruction
    output logic      [AW-1:0] pc_out         // Banked program counter
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    pmt_state_e state_r, state_nxt;
    logic [7:0]    tblp_r, tblp_nxt;
    logic [HW-1:0] tbhp_r, tbhp_nxt;
    logic [BB-1:0] bank_r, bank_nxt;
    logic [7:0]    latch_r, latch_nxt;
    logic [12:0]   pc_r, pc_nxt;
    logic [AW-1:0] ld_addr_r, ld_addr_nxt;
    logic          err_r, err_nxt;
    logic [7:0]    last_lo_r, last_lo_nxt;
    logic [1:0]    sec_r, sec_nxt;
    logic [7:0]    dst_r, dst_nxt;
    logic [31:0]   prdata_r, prdata_nxt;
    logic          pready_r, pready_nxt;
    logic          pslverr_r, pslverr_nxt;
    logic          dm_wr_en_r, dm_wr_en_nxt;
    logic [7:0]    dm_wr_data_r, dm_wr_data_nxt;
    logic          stall_r, stall_nxt;
    logic          phase_r, phase_nxt;    // Second fetch cycle

    logic              prep, done_xfer, wr_xfer;
    logic              cmd_ok, accept, tbl_done, latch_wr;
    logic [1:0]        cmd_mode, cmd_sec;
    logic              cmd_ext;
    logic [AW-1:0]     full_pc, rd_addr, mem_addr;
    logic              mem_we, mem_re;
    logic [15:0]       mem_rdata;

    // Mapped register check, used for reads and writes alike
    function automatic logic is_mapped(input logic [7:0] a);
        return a == PMT_OFS_TBLP || a == PMT_OFS_TBHP || a == PMT_OFS_BANK ||
               a == PMT_OFS_LATCH || a == PMT_OFS_PC  || a == PMT_OFS_CMD ||
               a == PMT_OFS_STAT || a == PMT_OFS_LDADDR ||
               a == PMT_OFS_LDDATA;
    endfunction

    // ----------------------------------------------------------------
    // Bus phases and command decode
    // ----------------------------------------------------------------
    // Prep is the first access cycle; the transfer ends one cycle later
    assign prep      = psel && penable && !pready_r;
    assign done_xfer = psel && penable && pready_r;
    assign wr_xfer   = done_xfer && pwrite;
    assign cmd_mode  = pwdata[PMT_CMD_MODE_LSB +: 2];
    assign cmd_ext   = pwdata[PMT_CMD_EXT_BIT];
    assign cmd_sec   = pwdata[PMT_CMD_SEC_LSB +: 2];
    // Ordinary form for sector 0, extended form elsewhere
    assign cmd_ok    = (state_r == PMT_IDLE) && (cmd_mode != 2'b11) &&
                       (cmd_ext == (cmd_sec != 2'b00));
    // Error answer decided at prep, so acceptance follows it
    assign accept    = wr_xfer && (paddr == PMT_OFS_CMD) && !pslverr_r;
    assign tbl_done  = (state_r == PMT_FETCH);
    assign latch_wr  = wr_xfer && (paddr == PMT_OFS_LATCH);
    // Bank bits sit above the 13-bit in-bank counter
    assign full_pc   = {bank_r, pc_r};

    // Table address per form
    always_comb begin
        case (cmd_mode)
            PMT_MODE_FULL: rd_addr = {tbhp_r, tblp_r};
            // Low pointer only replaces the page offset
            PMT_MODE_PAGE: rd_addr = {full_pc[AW-1:PMT_PAGE_BITS], tblp_r};
            // High pointer plays no part here
            PMT_MODE_LAST: rd_addr = {{HW{1'b1}}, tblp_r};
            default:       rd_addr = {tbhp_r, tblp_r};
        endcase
    end

    // Memory port: image loads and table fetches share it
    assign mem_we   = wr_xfer && (paddr == PMT_OFS_LDDATA) && !pslverr_r;
    assign mem_re   = accept;
    assign mem_addr = mem_we ? ld_addr_r : rd_addr;

    // 16-bit words, depth from the variant
    pmt_prog_mem #(
        .WORDS   (MEM_WORDS),
        .WIDTH   (PMT_WORD_BITS),
        .AW      (AW)
    ) u_mem (
        .pclk    (pclk),
        .wr_en   (mem_we),
        .addr    (mem_addr),
        .wr_data (pwdata[15:0]),
        .rd_en   (mem_re),
        .rd_data (mem_rdata)
    );

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // Software writes first, table completion overrides the latch
    always_comb begin
        state_nxt      = state_r;
        tblp_nxt       = tblp_r;
        tbhp_nxt       = tbhp_r;
        bank_nxt       = bank_r;
        latch_nxt      = latch_r;
        phase_nxt      = phase_r;
        pc_nxt         = pc_r;
        ld_addr_nxt    = ld_addr_r;
        err_nxt        = err_r;
        last_lo_nxt    = last_lo_r;
        sec_nxt        = sec_r;
        dst_nxt        = dst_r;
        dm_wr_en_nxt   = 1'b0;
        dm_wr_data_nxt = dm_wr_data_r;
        pready_nxt     = prep;
        pslverr_nxt    = 1'b0;
        prdata_nxt     = prdata_r;
        if (prep) begin
            pslverr_nxt = !is_mapped(paddr);
            if (pwrite && paddr == PMT_OFS_CMD) begin
                pslverr_nxt = !cmd_ok;
            end
            // Loading during a fetch would steal the memory port
            if (pwrite && paddr == PMT_OFS_LDDATA) begin
                pslverr_nxt = (state_r != PMT_IDLE);
            end
            case (paddr)
                PMT_OFS_TBLP:   prdata_nxt = {24'h000000, tblp_r};
                PMT_OFS_TBHP:   prdata_nxt = 32'(tbhp_r);
                PMT_OFS_BANK:   prdata_nxt = 32'(bank_r);
                PMT_OFS_LATCH:  prdata_nxt = {24'h000000, latch_r};
                PMT_OFS_PC:     prdata_nxt = {19'h00000, pc_r};
                PMT_OFS_STAT:   prdata_nxt = {16'h0000, last_lo_r, 6'h00,
                                              err_r, (state_r != PMT_IDLE)};
                PMT_OFS_LDADDR: prdata_nxt = 32'(ld_addr_r);
                default:        prdata_nxt = 32'h00000000;
            endcase
        end
        if (wr_xfer && !pslverr_r) begin
            case (paddr)
                PMT_OFS_TBLP:   tblp_nxt = pwdata[7:0];
                PMT_OFS_TBHP:   tbhp_nxt = pwdata[HW-1:0];
                PMT_OFS_BANK:   bank_nxt = pwdata[BB-1:0];
                PMT_OFS_LATCH:  latch_nxt = pwdata[7:0];
                PMT_OFS_PC:     pc_nxt = pwdata[12:0];
                PMT_OFS_LDADDR: ld_addr_nxt = pwdata[AW-1:0];
                PMT_OFS_LDDATA: ld_addr_nxt = ld_addr_r + AW'(1);
                PMT_OFS_STAT: begin
                    if (pwdata[PMT_STAT_ERR]) begin
                        err_nxt = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // Refused command flags an error; the set outranks a clear
        if (wr_xfer && paddr == PMT_OFS_CMD && pslverr_r) begin
            err_nxt = 1'b1;
        end
        case (state_r)
            PMT_IDLE: begin
                if (accept) begin
                    sec_nxt   = cmd_sec;
                    dst_nxt   = pwdata[PMT_CMD_DST_LSB +: 8];
                    state_nxt = PMT_FETCH;
                end
            end
            PMT_FETCH: begin
                // Word stands in the memory's output register; the core is
                // held a second cycle, then the results land
                if (!phase_r) begin
                    phase_nxt = 1'b1;
                end else begin
                    dm_wr_en_nxt   = 1'b1;
                    dm_wr_data_nxt = mem_rdata[7:0];
                    last_lo_nxt    = mem_rdata[7:0];
                    latch_nxt      = mem_rdata[15:8];
                    phase_nxt      = 1'b0;
                    state_nxt      = PMT_IDLE;
                end
            end
            default: state_nxt = PMT_IDLE;
        endcase
        // Core is held through both cycles of the read
        stall_nxt = accept || (state_r == PMT_FETCH && state_nxt != PMT_IDLE);
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Counter clears on every reset, giving the zero vector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r      <= PMT_IDLE;
            tblp_r       <= PMT_RST_BYTE;
            tbhp_r       <= '0;
            bank_r       <= '0;
            latch_r      <= PMT_RST_BYTE;
            phase_r      <= 1'b0;
            pc_r         <= PMT_RST_PC;
            ld_addr_r    <= '0;
            err_r        <= 1'b0;
            last_lo_r    <= PMT_RST_BYTE;
            sec_r        <= 2'b00;
            dst_r        <= PMT_RST_BYTE;
            prdata_r     <= 32'h00000000;
            pready_r     <= 1'b0;
            pslverr_r    <= 1'b0;
            dm_wr_en_r   <= 1'b0;
            dm_wr_data_r <= PMT_RST_BYTE;
            stall_r      <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            tblp_r       <= tblp_nxt;
            tbhp_r       <= tbhp_nxt;
            bank_r       <= bank_nxt;
            latch_r      <= latch_nxt;
            phase_r      <= phase_nxt;
            pc_r         <= pc_nxt;
            ld_addr_r    <= ld_addr_nxt;
            err_r        <= err_nxt;
            last_lo_r    <= last_lo_nxt;
            sec_r        <= sec_nxt;
            dst_r        <= dst_nxt;
            prdata_r     <= prdata_nxt;
            pready_r     <= pready_nxt;
            pslverr_r    <= pslverr_nxt;
            dm_wr_en_r   <= dm_wr_en_nxt;
            dm_wr_data_r <= dm_wr_data_nxt;
            stall_r      <= stall_nxt;
        end
    end

    // Outputs straight from flops
    assign prdata       = prdata_r;
    assign pready       = pready_r;
    assign pslverr      = pslverr_r;
    assign dm_wr_en     = dm_wr_en_r;
    assign dm_wr_sector = sec_r;
    assign dm_wr_addr   = dst_r;
    assign dm_wr_data   = dm_wr_data_r;
    assign core_stall   = stall_r;
    assign pc_out       = full_pc;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // Helper: high only in the first cycle after reset release
    logic first_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_r <= 1'b1;
        end else begin
            first_r <= 1'b0;
        end
    end

    sequence s_two_cycle_read;
        core_stall ##1 (core_stall && dm_wr_en == 1'b0) ##1 (!core_stall && dm_wr_en);
    endsequence

    property p_two_cycles;
        @(posedge pclk) disable iff (!presetn) accept |=> s_two_cycle_read;
    endproperty
    a_two_cycles: assert property (p_two_cycles)
        else $error("table read did not take two cycles");

    property p_low_byte;
        @(posedge pclk) disable iff (!presetn)
            dm_wr_en |-> dm_wr_data == $past(mem_rdata[7:0]);
    endproperty
    a_low_byte: assert property (p_low_byte)
        else $error("destination byte is not the low table byte");

    property p_high_byte;
        @(posedge pclk) disable iff (!presetn)
            dm_wr_en |-> latch_r == $past(mem_rdata[15:8]);
    endproperty
    a_high_byte: assert property (p_high_byte)
        else $error("latch did not take the high table byte");

    property p_latch_hold;
        @(posedge pclk) disable iff (!presetn)
            (!tbl_done && !latch_wr) |=> $stable(latch_r);
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latch changed without a cause");

    property p_ext_form;
        @(posedge pclk) disable iff (!presetn)
            accept |-> cmd_ext == (cmd_sec != 2'b00);
    endproperty
    a_ext_form: assert property (p_ext_form)
        else $error("form does not match destination sector");

    property p_last_page;
        @(posedge pclk) disable iff (!presetn)
            (accept && cmd_mode == PMT_MODE_LAST) |->
            (&rd_addr[AW-1:PMT_PAGE_BITS]) && rd_addr[7:0] == tblp_r;
    endproperty
    a_last_page: assert property (p_last_page)
        else $error("last page address wrong");

    property p_page_rel;
        @(posedge pclk) disable iff (!presetn)
            (accept && cmd_mode == PMT_MODE_PAGE) |->
            rd_addr == {full_pc[AW-1:PMT_PAGE_BITS], tblp_r};
    endproperty
    a_page_rel: assert property (p_page_rel)
        else $error("page relative address wrong");

    property p_full_addr;
        @(posedge pclk) disable iff (!presetn)
            (accept && cmd_mode == PMT_MODE_FULL) |-> rd_addr == {tbhp_r, tblp_r};
    endproperty
    a_full_addr: assert property (p_full_addr)
        else $error("full table address wrong");

    property p_pc_reset;
        @(posedge pclk) disable iff (!presetn) first_r |-> pc_out == '0;
    endproperty
    a_pc_reset: assert property (p_pc_reset)
        else $error("program counter not zero after reset");
endmodule
